/* inc/rsi_pkg.sv */
package rsi_pkg;
  // ****************************************
  // bus and command carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } rsi_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } rsi_axi_rsp_t;

  typedef struct packed {
    logic [7:0] code;
    logic [31:0] param;
  } rsi_cmd_t;

  // ****************************************
  // exposure sequencer states
  // ****************************************
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_FLUSH = 10'h002,
    ST_LEDON = 10'h004,
    ST_EXPOSE = 10'h008,
    ST_LEDOFF = 10'h010,
    ST_BOOK = 10'h020,
    ST_ROSTART = 10'h040,
    ST_ROWAIT = 10'h080,
    ST_SYNC = 10'h100,
    ST_SWAP = 10'h200
  } rsi_state_t;

  // ****************************************
  // register offsets, byte addresses
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ID_MIRROR = 8'h08;
  localparam logic [7:0] OFF_LOOP_COMP = 8'h0c;
  localparam logic [7:0] OFF_EXPOSE_CFG = 8'h10;
  localparam logic [7:0] OFF_REPEAT_CFG = 8'h14;
  localparam logic [7:0] OFF_SCIENCE_CFG = 8'h18;
  localparam logic [7:0] OFF_MIRROR_POS = 8'h1c;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // reset values of configuration words
  // ****************************************
  localparam logic [31:0] RST_ID_MIRROR = 32'h0000_0000;
  localparam logic [31:0] RST_LOOP_COMP = 32'h0000_0001;
  localparam logic [31:0] RST_EXPOSE_CFG = 32'h0f01_0001;
  localparam logic [31:0] RST_REPEAT_CFG = 32'h0023_0001;
  localparam logic [31:0] RST_SCIENCE_CFG = 32'h0000_0000;

  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] CMD_FLAT_FIELD = 8'h8e;
  localparam logic [7:0] CMD_LOOP_BACK = 8'h89;
  localparam logic [7:0] CAMERA_FIRST = 8'h40;
  localparam logic [7:0] CAMERA_LAST = 8'h4f;
  localparam logic [7:0] MECH_FIRST = 8'h50;
  localparam logic [7:0] MECH_LAST = 8'h6f;
  localparam logic [7:0] CAMERA_GEN_START = 8'h42;
  localparam logic [7:0] CAMERA_GEN_DUMP = 8'h43;
  localparam logic [7:0] CAMERA_GEN_UPLOAD = 8'h46;
  localparam logic [7:0] CAMERA_HK_REQ = 8'h47;
  localparam logic [7:0] CAMERA_AE_HK_REQ = 8'h49;
  localparam logic [7:0] MECH_ARM = 8'h5d;
  localparam logic [7:0] MECH_DISARM = 8'h56;
  localparam logic [7:0] MECH_FIRE = 8'h5e;
  localparam logic [7:0] MECH_DUMP = 8'h64;
  localparam logic [7:0] MECH_UPLOAD = 8'h63;
  localparam logic [7:0] MECH_HK_REQ = 8'h60;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned EXP_UNIT_MS = 10;
  localparam int unsigned EXP_UNIT_CYCLES = EXP_UNIT_MS * 1000000 / CLK_PERIOD_NS;
endpackage : rsi_pkg

/* tb/rsi_far_model.sv */
// ****
// camera and mechanism controller model
// ****
module rsi_far_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic flushReq,
  input wire logic roStart,
  output logic fwdReady,
  output logic flushDone,
  output logic roDone
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] tick;
  int flushWait;
  int roWait;

  // slow mode stalls commands and stretches flush and read-out
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tick <= 3'h0;
      fwdReady <= 1'b0;
      flushDone <= 1'b0;
      roDone <= 1'b0;
      flushWait <= 0;
      roWait <= 0;
    end else begin
      tick <= tick + 3'h1;
      fwdReady <= slow ? (tick == 3'h0) : 1'b1;
      flushDone <= (flushWait == 1);
      roDone <= (roWait == 1);
      flushWait <= flushReq ? (slow ? 12 : 1) : (flushWait != 0 ? flushWait - 1 : 0);
      roWait <= roStart ? (slow ? 20 : 1) : (roWait != 0 ? roWait - 1 : 0);
    end
  end
endmodule : rsi_far_model

/* tb/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  localparam int LIM = 400;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic cmdValid = 1'b0;
  logic pixValid = 1'b0;
  logic slow = 1'b0;
  logic pvPrev = 1'b0;
  logic [1:0] pixNode = 2'h0;
  rsi_pkg::rsi_axi_req_t axiReq = '0;
  rsi_pkg::rsi_cmd_t cmdIn = '0;
  rsi_pkg::rsi_axi_rsp_t axiRsp;
  rsi_pkg::rsi_cmd_t fwdCmd;
  logic cmdReady, fwdValid, fwdReady, fwdToMech, flushReq, flushDone, roStart, roDone;
  logic acqSync, bufSel, mirrorStep, compStep, compBackward, jumpLoop, jumpRaster, rasterEnd;
  logic compressBypass, binX, binY, trigExtFlare, trigAutoExp, trigEvent, trigIntFlare;
  logic [1:0] ledOn;
  logic [6:0] compSteps;
  logic [3:0] segWrite;
  logic [7:0] flushCount;
  logic [3:0] flushSeqId, roSeqId;
  logic [15:0] mirrorDelta;
  logic [8:0] fwdQ[$];
  logic [3:0] segQ[$];
  logic [3:0] lbExp[4] = '{4'h8, 4'h7, 4'h8, 4'h5};
  int failures = 0;
  int comparisons = 0;
  int seed = 92;

  always #5 mclk = ~mclk;

  rsi_interpreter #(.TICK_CYCLES(TICK)) dut (.mclk, .reset_n, .axiReq, .axiRsp, .cmdValid,
    .cmdReady, .cmdIn, .fwdValid, .fwdReady, .fwdCmd, .fwdToMech, .flushReq, .flushCount,
    .flushSeqId, .flushDone, .ledOn, .roStart, .roSeqId, .roDone, .acqSync, .bufSel,
    .mirrorStep, .mirrorDelta, .compStep, .compBackward, .compSteps, .jumpLoop, .jumpRaster,
    .rasterEnd, .pixValid, .pixNode, .segWrite, .compressBypass, .binX, .binY, .trigExtFlare,
    .trigAutoExp, .trigEvent, .trigIntFlare);

  rsi_far_model far (.mclk, .reset_n, .slow, .flushReq, .roStart, .fwdReady, .flushDone,
    .roDone);

  // ****
  // checking and closing
  // ****
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic lim(input int n);
    if (n >= LIM) begin
      failures++;
      complete_run();
    end
  endtask : lim

  // results sampled mid-cycle, where they are settled
  always @(negedge mclk) begin
    if (fwdValid && fwdReady) begin
      chk("fwdCmd", {fwdToMech, fwdCmd.code}, fwdQ.size() ? fwdQ.pop_front() : 9'hx);
    end
    if (pvPrev) begin
      chk("segWrite", segWrite, segQ.size() ? segQ.pop_front() : 4'hx);
    end
    pvPrev = pixValid;
  end

  // ****
  // bus and command drivers
  // ****
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    axiReq.awaddr <= a;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hf;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    do begin @(negedge mclk); n++; end while (!axiRsp.awready && n < LIM);
    @(posedge mclk);
    axiReq.awvalid <= 1'b0;
    axiReq.wvalid <= 1'b0;
    do begin @(negedge mclk); n++; end while (!axiRsp.bvalid && n < LIM);
    @(posedge mclk);
    axiReq.bready <= 1'b0;
    lim(n);
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    do begin @(negedge mclk); n++; end while (!axiRsp.arready && n < LIM);
    @(posedge mclk);
    axiReq.arvalid <= 1'b0;
    do begin @(negedge mclk); n++; end while (!axiRsp.rvalid && n < LIM);
    d = axiRsp.rdata;
    r = axiRsp.rresp;
    @(posedge mclk);
    axiReq.rready <= 1'b0;
    lim(n);
  endtask : axr

  // leading edge keeps two offers from landing in one time step
  task automatic cmd(input logic [7:0] c, input logic [31:0] p);
    int n;
    n = 0;
    @(posedge mclk);
    cmdIn.code <= c;
    cmdIn.param <= p;
    cmdValid <= 1'b1;
    do begin @(negedge mclk); n++; end while (!cmdReady && n < LIM);
    @(posedge mclk);
    cmdValid <= 1'b0;
    lim(n);
  endtask : cmd

  // ****
  // main sequence
  // ****
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] c;
    logic [7:0] cb;
    logic [3:0] nodes;
    logic b0;
    int n, tFl, tLed, tRo, tAcq, ledCnt;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    axr(rsi_pkg::OFF_EXPOSE_CFG, d, r);
    chk("exposeReset", d, rsi_pkg::RST_EXPOSE_CFG);
    axr(8'h40, d, r);
    chk("unmappedResp", r, rsi_pkg::RESP_SLVERR);
    chk("unmappedData", d, 32'h0);
    c = $random(seed);
    cb = $random(seed);
    nodes = $random(seed);
    axw(rsi_pkg::OFF_SCIENCE_CFG, {16'h0003, 6'h0, c[1:0], c});
    chk("trig", {trigIntFlare, trigEvent, trigAutoExp, trigExtFlare}, c[5:2]);
    chk("bin", {binY, binX}, c[1:0]);
    chk("stepSize", mirrorDelta, 16'h0003);
    axw(rsi_pkg::OFF_EXPOSE_CFG, {4'h0, nodes, 8'h01, cb, 8'h01});
    chk("comp", {compBackward, compSteps}, cb);
    axw(rsi_pkg::OFF_LOOP_COMP, 32'h0000_0001);
    chk("bypass", compressBypass, 1'b1);
    axw(rsi_pkg::OFF_LOOP_COMP, 32'h0005_0001);
    chk("noBypass", compressBypass, 1'b0);
    // random pixel nodes, one per cycle, against the enabled segments
    for (n = 0; n < 24; n++) begin
      c = $random(seed);
      pixValid <= 1'b1;
      pixNode <= c[1:0];
      segQ.push_back(nodes & (4'h1 << c[1:0]));
      @(posedge mclk);
    end
    pixValid <= 1'b0;
    // every camera and mechanism code, stalling on odd codes
    for (n = 'h40; n < 'h70; n++) begin
      c = n[7:0];
      slow <= n[0];
      if (c inside {8'h42, 8'h43, 8'h46, 8'h47, 8'h49,
                    8'h5d, 8'h56, 8'h5e, 8'h64, 8'h63, 8'h60}) begin
        cmd(c, 32'h0);
        axr(rsi_pkg::OFF_STATUS, d, r);
        chk("errFlag", d[1], 1'b1);
        axw(rsi_pkg::OFF_STATUS, 32'h2);
      end else begin
        fwdQ.push_back({c >= rsi_pkg::MECH_FIRST, c});
        cmd(c, n);
      end
    end
    axr(rsi_pkg::OFF_STATUS, d, r);
    chk("errCleared", d[1], 1'b0);
    // flat fields with one flush, both lamps, two time units
    // read-out id 3 is unbinned, so coordinates need no halving
    axw(rsi_pkg::OFF_REPEAT_CFG, 32'h0123_0001);
    chk("seqCfg", {flushCount, flushSeqId, roSeqId}, 16'h0123);
    // one exposure per position first, then two: the mirror waits for the set
    for (int k = 0; k < 3; k++) begin
      b0 = bufSel;
      cmd(rsi_pkg::CMD_FLAT_FIELD, 32'h0003_0002);
      tFl = 0;
      tLed = 0;
      tRo = 0;
      tAcq = 0;
      ledCnt = 0;
      for (n = 1; n < LIM && !(cmdReady && tAcq != 0); n++) begin
        @(negedge mclk);
        if (flushReq) tFl = n;
        if (ledOn == 2'h3 && tLed == 0) tLed = n;
        ledCnt += (ledOn == 2'h3);
        if (roStart) tRo = n;
        if (roStart) chk("mirrorStep", mirrorStep, k != 1);
        if (acqSync) tAcq = n;
      end
      lim(n);
      chk("order", {tFl > 0, tLed > tFl, tRo > tLed, tAcq > tRo}, 4'hf);
      chk("ledTime", ledCnt >= 2 * TICK && ledCnt <= 2 * TICK + 2, 1'b1);
      chk("bufSwap", bufSel, !b0);
      if (k == 0) axw(rsi_pkg::OFF_EXPOSE_CFG, {4'h0, nodes, 8'h01, cb, 8'h02});
    end
    // three exposures, two steps of three
    axr(rsi_pkg::OFF_MIRROR_POS, d, r);
    chk("mirrorPos", d, 32'h0003_0006);
    // two loops, two repeats, compensation every raster
    axw(rsi_pkg::OFF_LOOP_COMP, 32'h0000_0002);
    axw(rsi_pkg::OFF_REPEAT_CFG, 32'h0023_0002);
    axw(rsi_pkg::OFF_CTRL, 32'h1);
    for (n = 0; n < 4; n++) begin
      cmd(rsi_pkg::CMD_LOOP_BACK, 32'h0);
      @(negedge mclk);
      chk("loopJumps", {jumpLoop, rasterEnd, jumpRaster, compStep}, lbExp[n]);
    end
    axr(rsi_pkg::OFF_STATUS, d, r);
    chk("rasterDone", d[2], 1'b1);
    complete_run();
  end
endmodule : tb_top

/* verilog/rsi_cmd_filter.sv */
// ****************************************
// sequence command classifier
// ****************************************
module rsi_cmd_filter (
  input logic [7:0] code,
  output logic toMech,
  output logic excluded,
  output logic forward
);
  logic isCamera;
  logic isMech;

  // subsystem ranges
  assign isCamera = (code >= rsi_pkg::CAMERA_FIRST) && (code <= rsi_pkg::CAMERA_LAST);
  assign isMech = (code >= rsi_pkg::MECH_FIRST) && (code <= rsi_pkg::MECH_LAST);
  assign toMech = isMech;

  // ground-only and internally handled codes never leave a sequence
  always_comb begin
    unique case (code)
      rsi_pkg::CAMERA_GEN_START, rsi_pkg::CAMERA_GEN_DUMP, rsi_pkg::CAMERA_GEN_UPLOAD,
      rsi_pkg::CAMERA_HK_REQ, rsi_pkg::CAMERA_AE_HK_REQ: excluded = 1'b1;
      rsi_pkg::MECH_ARM, rsi_pkg::MECH_DISARM, rsi_pkg::MECH_FIRE,
      rsi_pkg::MECH_DUMP, rsi_pkg::MECH_UPLOAD, rsi_pkg::MECH_HK_REQ: excluded = 1'b1;
      default: excluded = 1'b0;
    endcase
  end

  assign forward = (isCamera || isMech) && !excluded;
endmodule : rsi_cmd_filter

/* verilog/rsi_interpreter.sv */
// How it works
// - flat field: flush, LEDs, wait, off, read-out, swap
// - forward camera commands except excluded codes
// - never forward excluded mechanism commands
// - compression zero means data bypass
// - exposures per position low nibble, one to eight; the code takes any value up to fifteen
// - compensation byte: top bit direction, low seven bits step count
// - compensation once every skip rasters
// - mirror advances by step size; zero stays
// - mirror step overlaps CCD read-out
// - step only after last exposure of set
// - four read-out node enable bits
// - steer pixels to enabled buffer segments
// - repeats decrement; nonzero re-enters raster
// - science byte bits enable four triggers
// - copy binning flags into science packets
// - exposure time counts ten millisecond units
module rsi_interpreter #(
  parameter int unsigned TICK_CYCLES = rsi_pkg::EXP_UNIT_CYCLES
) (
  input logic mclk,
  input logic reset_n,
  input rsi_pkg::rsi_axi_req_t axiReq,
  output rsi_pkg::rsi_axi_rsp_t axiRsp,
  input logic cmdValid,
  output logic cmdReady,
  input rsi_pkg::rsi_cmd_t cmdIn,
  output logic fwdValid,
  input logic fwdReady,
  output rsi_pkg::rsi_cmd_t fwdCmd,
  output logic fwdToMech,
  output logic flushReq,
  output logic [7:0] flushCount,
  output logic [3:0] flushSeqId,
  input logic flushDone,
  output logic [1:0] ledOn,
  output logic roStart,
  output logic [3:0] roSeqId,
  input logic roDone,
  output logic acqSync,
  output logic bufSel,
  output logic mirrorStep,
  output logic [15:0] mirrorDelta,
  output logic compStep,
  output logic compBackward,
  output logic [6:0] compSteps,
  output logic jumpLoop,
  output logic jumpRaster,
  output logic rasterEnd,
  input logic pixValid,
  input logic [1:0] pixNode,
  output logic [3:0] segWrite,
  output logic compressBypass,
  output logic binX,
  output logic binY,
  output logic trigExtFlare,
  output logic trigAutoExp,
  output logic trigEvent,
  output logic trigIntFlare
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    rsi_pkg::rsi_state_t st;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] cfgId;
    logic [31:0] cfgLoop;
    logic [31:0] cfgExp;
    logic [31:0] cfgRep;
    logic [31:0] cfgSci;
    logic running;
    logic err;
    logic done;
    logic [15:0] loopsLeft;
    logic [11:0] repLeft;
    logic [7:0] skipCnt;
    logic [3:0] expIdx;
    logic [15:0] mirrorPos;
    logic [15:0] expCount;
    logic [15:0] expUnits;
    logic [31:0] tick;
    logic [1:0] ledSel;
    logic [1:0] ledOut;
    rsi_pkg::rsi_cmd_t fwdCmd;
    logic fwdValid;
    logic fwdToMech;
    logic flushReq;
    logic roStart;
    logic acqSync;
    logic bufSel;
    logic mirrorStep;
    logic compStep;
    logic jumpLoop;
    logic jumpRaster;
    logic rasterEnd;
    logic [3:0] segWrite;
  } rsi_main_t;

  rsi_main_t s;
  rsi_main_t next_s;
  logic take;
  logic isMech;
  logic excl;
  logic fwdOk;
  logic wrTake;
  logic lastExp;

  // merge a write under its byte strobes
  function automatic logic [31:0] rsi_merge(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction : rsi_merge

  rsi_cmd_filter u_filter (
    .code(cmdIn.code),
    .toMech(isMech),
    .excluded(excl),
    .forward(fwdOk)
  );

  // ****************************************
  // handshakes and decoded outputs
  // ****************************************
  // one write at a time; address and data are taken in the same edge
  assign wrTake = axiReq.awvalid && axiReq.wvalid && !s.bvalid;
  assign axiRsp.awready = wrTake;
  assign axiRsp.wready = wrTake;
  assign axiRsp.bvalid = s.bvalid;
  assign axiRsp.bresp = s.bresp;
  assign axiRsp.arready = !s.rvalid;
  assign axiRsp.rvalid = s.rvalid;
  assign axiRsp.rdata = s.rdata;
  assign axiRsp.rresp = s.rresp;
  // a pending forward stalls the sequence rather than being overwritten
  assign cmdReady = (s.st == rsi_pkg::ST_IDLE) && !s.fwdValid;
  assign take = cmdValid && cmdReady;
  // values above eight are out of range; zero behaves as one
  assign lastExp = ({1'b0, s.expIdx} + 5'h01) >= {1'b0, s.cfgExp[3:0]};

  assign fwdValid = s.fwdValid;
  assign fwdCmd = s.fwdCmd;
  assign fwdToMech = s.fwdToMech;
  assign flushReq = s.flushReq;
  assign flushCount = s.cfgRep[31:24];
  assign flushSeqId = s.cfgRep[23:20];
  assign roSeqId = s.cfgRep[19:16];
  assign ledOn = s.ledOut;
  assign roStart = s.roStart;
  assign acqSync = s.acqSync;
  assign bufSel = s.bufSel;
  assign mirrorStep = s.mirrorStep;
  assign mirrorDelta = s.cfgSci[31:16];
  assign compStep = s.compStep;
  assign compBackward = s.cfgExp[15];
  assign compSteps = s.cfgExp[14:8];
  assign jumpLoop = s.jumpLoop;
  assign jumpRaster = s.jumpRaster;
  assign rasterEnd = s.rasterEnd;
  assign segWrite = s.segWrite;
  assign compressBypass = (s.cfgLoop[31:16] == 16'h0000);
  assign binX = s.cfgSci[8];
  assign binY = s.cfgSci[9];
  assign trigExtFlare = s.cfgSci[2];
  assign trigAutoExp = s.cfgSci[3];
  assign trigEvent = s.cfgSci[4];
  assign trigIntFlare = s.cfgSci[5];

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.flushReq = 1'b0;
    next_s.roStart = 1'b0;
    next_s.acqSync = 1'b0;
    next_s.mirrorStep = 1'b0;
    next_s.compStep = 1'b0;
    next_s.jumpLoop = 1'b0;
    next_s.jumpRaster = 1'b0;
    next_s.rasterEnd = 1'b0;
    // register bus write, before hardware sets so that sets win
    if (s.bvalid && axiReq.bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wrTake) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = rsi_pkg::RESP_OKAY;
      unique case (axiReq.awaddr & 8'hfc)
        rsi_pkg::OFF_CTRL: begin
          if (axiReq.wstrb[0] && axiReq.wdata[0]) begin
            next_s.running = 1'b1;
            next_s.done = 1'b0;
            next_s.loopsLeft = s.cfgLoop[15:0];
            next_s.repLeft = s.cfgRep[11:0];
            next_s.skipCnt = 8'h00;
            next_s.expIdx = 4'h0;
            next_s.mirrorPos = s.cfgId[31:16];
          end
          if (axiReq.wstrb[0] && axiReq.wdata[1]) begin
            next_s.running = 1'b0;
          end
        end
        rsi_pkg::OFF_STATUS: begin
          if (axiReq.wstrb[0]) begin
            next_s.err = s.err && !axiReq.wdata[1];
            next_s.done = s.done && !axiReq.wdata[2];
          end
        end
        rsi_pkg::OFF_ID_MIRROR: next_s.cfgId = rsi_merge(s.cfgId, axiReq.wdata, axiReq.wstrb);
        rsi_pkg::OFF_LOOP_COMP: next_s.cfgLoop = rsi_merge(s.cfgLoop, axiReq.wdata, axiReq.wstrb);
        rsi_pkg::OFF_EXPOSE_CFG: next_s.cfgExp = rsi_merge(s.cfgExp, axiReq.wdata, axiReq.wstrb);
        rsi_pkg::OFF_REPEAT_CFG: next_s.cfgRep = rsi_merge(s.cfgRep, axiReq.wdata, axiReq.wstrb);
        rsi_pkg::OFF_SCIENCE_CFG: next_s.cfgSci = rsi_merge(s.cfgSci, axiReq.wdata, axiReq.wstrb);
        rsi_pkg::OFF_MIRROR_POS: next_s.bresp = rsi_pkg::RESP_OKAY;
        default: next_s.bresp = rsi_pkg::RESP_SLVERR;
      endcase
    end
    // register bus read, one cycle after the address is taken
    if (s.rvalid && axiReq.rready) begin
      next_s.rvalid = 1'b0;
    end
    if (axiReq.arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = rsi_pkg::RESP_OKAY;
      unique case (axiReq.araddr & 8'hfc)
        rsi_pkg::OFF_CTRL: next_s.rdata = 32'h0000_0000;
        rsi_pkg::OFF_STATUS: next_s.rdata = {12'h000, s.repLeft, s.expIdx, 1'b0, s.done,
                                             s.err, s.running};
        rsi_pkg::OFF_ID_MIRROR: next_s.rdata = s.cfgId;
        rsi_pkg::OFF_LOOP_COMP: next_s.rdata = s.cfgLoop;
        rsi_pkg::OFF_EXPOSE_CFG: next_s.rdata = s.cfgExp;
        rsi_pkg::OFF_REPEAT_CFG: next_s.rdata = s.cfgRep;
        rsi_pkg::OFF_SCIENCE_CFG: next_s.rdata = s.cfgSci;
        rsi_pkg::OFF_MIRROR_POS: next_s.rdata = {s.expCount, s.mirrorPos};
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = rsi_pkg::RESP_SLVERR;
        end
      endcase
    end
    // forwarded command holds until the subsystem takes it
    if (s.fwdValid && fwdReady) begin
      next_s.fwdValid = 1'b0;
    end
    // pixel steering into the enabled buffer segments
    next_s.segWrite = pixValid ? (s.cfgExp[27:24] & (4'h1 << pixNode)) : 4'h0;
    // exposure sequencer and command intake
    unique case (s.st)
      rsi_pkg::ST_IDLE: begin
        if (take) begin
          if (cmdIn.code == rsi_pkg::CMD_FLAT_FIELD) begin
            next_s.expUnits = cmdIn.param[15:0];
            next_s.ledSel = cmdIn.param[17:16];
            if (s.cfgRep[31:24] != 8'h00) begin
              next_s.flushReq = 1'b1;
              next_s.st = rsi_pkg::ST_FLUSH;
            end else begin
              next_s.st = rsi_pkg::ST_LEDON;
            end
          end else if (cmdIn.code == rsi_pkg::CMD_LOOP_BACK) begin
            // a loop count of zero is treated as one
            if (s.loopsLeft > 16'h0001) begin
              next_s.loopsLeft = s.loopsLeft - 16'h0001;
              next_s.jumpLoop = 1'b1;
            end else begin
              next_s.rasterEnd = 1'b1;
              if ((s.skipCnt + 8'h01) >= s.cfgExp[23:16]) begin
                next_s.compStep = 1'b1;
                next_s.skipCnt = 8'h00;
              end else begin
                next_s.skipCnt = s.skipCnt + 8'h01;
              end
              if (s.repLeft > 12'h001) begin
                next_s.repLeft = s.repLeft - 12'h001;
                next_s.jumpRaster = 1'b1;
                next_s.loopsLeft = s.cfgLoop[15:0];
                next_s.mirrorPos = s.cfgId[31:16];
                next_s.expIdx = 4'h0;
              end else begin
                next_s.repLeft = 12'h000;
                next_s.running = 1'b0;
                next_s.done = 1'b1;
              end
            end
          end else if (fwdOk) begin
            next_s.fwdValid = 1'b1;
            next_s.fwdCmd = cmdIn;
            next_s.fwdToMech = isMech;
          end else if (excl) begin
            next_s.err = 1'b1;
          end
        end
      end
      rsi_pkg::ST_FLUSH: begin
        if (flushDone) begin
          next_s.st = rsi_pkg::ST_LEDON;
        end
      end
      rsi_pkg::ST_LEDON: begin
        next_s.ledOut = s.ledSel;
        next_s.tick = 32'h0000_0000;
        next_s.st = rsi_pkg::ST_EXPOSE;
      end
      rsi_pkg::ST_EXPOSE: begin
        // each unit of exposure time is a full tick period
        if (s.expUnits == 16'h0000) begin
          next_s.st = rsi_pkg::ST_LEDOFF;
        end else if (s.tick == TICK_CYCLES - 1) begin
          next_s.tick = 32'h0000_0000;
          next_s.expUnits = s.expUnits - 16'h0001;
        end else begin
          next_s.tick = s.tick + 32'h0000_0001;
        end
      end
      rsi_pkg::ST_LEDOFF: begin
        next_s.ledOut = 2'h0;
        next_s.st = rsi_pkg::ST_BOOK;
      end
      rsi_pkg::ST_BOOK: begin
        next_s.expCount = s.expCount + 16'h0001;
        next_s.st = rsi_pkg::ST_ROSTART;
      end
      rsi_pkg::ST_ROSTART: begin
        next_s.roStart = 1'b1;
        // the mirror moves during read-out to hide its settling time
        if (lastExp) begin
          next_s.expIdx = 4'h0;
          next_s.mirrorStep = (s.cfgSci[31:16] != 16'h0000);
          next_s.mirrorPos = s.mirrorPos + s.cfgSci[31:16];
        end else begin
          next_s.expIdx = s.expIdx + 4'h1;
        end
        next_s.st = rsi_pkg::ST_ROWAIT;
      end
      rsi_pkg::ST_ROWAIT: begin
        if (roDone) begin
          next_s.st = rsi_pkg::ST_SYNC;
        end
      end
      rsi_pkg::ST_SYNC: begin
        next_s.acqSync = 1'b1;
        next_s.st = rsi_pkg::ST_SWAP;
      end
      rsi_pkg::ST_SWAP: begin
        next_s.bufSel = !s.bufSel;
        next_s.st = rsi_pkg::ST_IDLE;
      end
      default: next_s.st = rsi_pkg::ST_IDLE;
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.st <= rsi_pkg::ST_IDLE;
      s.cfgId <= rsi_pkg::RST_ID_MIRROR;
      s.cfgLoop <= rsi_pkg::RST_LOOP_COMP;
      s.cfgExp <= rsi_pkg::RST_EXPOSE_CFG;
      s.cfgRep <= rsi_pkg::RST_REPEAT_CFG;
      s.cfgSci <= rsi_pkg::RST_SCIENCE_CFG;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  ff_order_a: assert property (s.st == rsi_pkg::ST_LEDOFF |=> s.st == rsi_pkg::ST_BOOK ##1
    s.st == rsi_pkg::ST_ROSTART ##1 s.st == rsi_pkg::ST_ROWAIT && s.roStart)
    else $error("exposure steps out of order");
  led_window_a: assert property (s.st == rsi_pkg::ST_EXPOSE |-> ledOn == s.ledSel)
    else $error("LEDs not lit during exposure");
  excl_drop_a: assert property (take && excl |=> s.err && !s.fwdValid)
    else $error("excluded command not dropped");
  fwd_pass_a: assert property (take && fwdOk |=> fwdValid &&
    fwdCmd.code == $past(cmdIn.code))
    else $error("allowed command not forwarded");
  bypass_a: assert property (wrTake && axiReq.awaddr == rsi_pkg::OFF_LOOP_COMP &&
    axiReq.wstrb == 4'hf |=> compressBypass == ($past(axiReq.wdata) < 32'h0001_0000))
    else $error("compression bypass wrong");
  step_last_a: assert property (mirrorStep |-> roStart && s.expIdx == 4'h0 &&
    mirrorDelta != 16'h0000)
    else $error("mirror step outside read-out start");
  comp_skip_a: assert property (compStep |-> rasterEnd && s.skipCnt == 8'h00)
    else $error("compensation off its raster");
  seg_mask_a: assert property (segWrite != 4'h0 |-> $past(pixValid) &&
    (segWrite & ~s.cfgExp[27:24]) == 4'h0)
    else $error("pixel sent to disabled segment");
  repeat_a: assert property (take && cmdIn.code == rsi_pkg::CMD_LOOP_BACK &&
    s.loopsLeft <= 16'h0001 && s.repLeft > 12'h001 |=> jumpRaster ##0
    s.repLeft == $past(s.repLeft) - 12'h001)
    else $error("raster repeat not re-entered");

  ff_done_c: cover property (s.st == rsi_pkg::ST_SWAP);
  excl_c: cover property (take && excl);
  jump_c: cover property (jumpRaster);
  comp_c: cover property (compStep && mirrorDelta != 16'h0000);
endmodule : rsi_interpreter
